// ---- verif/position_value_io_tb.sv ----
// self-checking bench for the position value and switching port block
`timescale 1ns/1ns
`default_nettype none
module position_value_io_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic mv = 1'b0;
  logic signed [31:0] md = 32'sh0;
  logic me = 1'b0;
  logic [7:0] cond = 8'h00;
  logic signed [31:0] pos;
  logic pv;
  logic pos_err;
  logic laser_on;
  logic io1_in, io1_out, io1_oe, io2_in, io2_out, io2_oe, irq;
  logic ext1 = 1'b1;
  logic ext2 = 1'b1;
  logic [31:0] r;
  logic e;
  int errors = 0;
  int num_checks = 0;
  int n;
  always #25 clk = ~clk;
  position_value_io #(.TICK_CYCLES(4)) dut (.i_core_clk(clk), .i_rstn(rstn),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_meas_valid(mv),
    .i_meas_dist(md), .i_meas_error(me), .i_cond(cond), .o_pos(pos), .o_pos_valid(pv),
    .o_pos_error(pos_err), .o_laser_on(laser_on), .i_io1(io1_in), .o_io1(io1_out),
    .o_io1_oe(io1_oe), .i_io2(io2_in), .o_io2(io2_out), .o_io2_oe(io2_oe), .o_irq(irq));
  sw_line_model m1 (.i_oe(io1_oe), .i_out(io1_out), .i_ext(ext1), .o_level(io1_in));
  sw_line_model m2 (.i_oe(io2_oe), .i_out(io2_out), .i_ext(ext2), .o_level(io2_in));
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 20 && prdy !== 1'b1; k++) @(posedge clk);
    if (k == 20) begin errors++; wrap_up(); end
    r = prd; e = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask
  // bounded wait for the next position update
  task automatic wait_pos;
    // step past a valid pulse that may still be showing
    @(posedge clk);
    for (n = 0; n < 400 && pv !== 1'b1; n++) @(posedge clk);
    if (n == 400) begin errors++; wrap_up(); end
  endtask
  task automatic meas(input logic signed [31:0] d, input logic [31:0] x, input string nm);
    @(posedge clk); mv <= 1'b1; md <= d;
    @(posedge clk); mv <= 1'b0;
    wait_pos();
    chk(nm, x, pos);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdc(posval_pkg::CTRL_OFS, 32'h4, "ctrl");
    rdc(posval_pkg::RES_OFS, 32'h3E8, "res");
    rdc(posval_pkg::DELAY_OFS, 32'h64, "delay");
    rdc(posval_pkg::IO1_OFS, 32'hC00, "io1 cfg");
    rdc(posval_pkg::IO2_OFS, 32'h380, "io2 cfg");
    cond <= 8'h80;
    repeat (4) @(posedge clk);
    chk("io1 pin", 32'h0, io1_out);
    chk("io2 pin", 32'h1, io2_out);
    cond <= 8'h08;
    repeat (4) @(posedge clk);
    chk("io2 on", 32'h0, io2_out);
    $display("test defaults done");
    meas(5000, 5, "metric");
    wr(posval_pkg::OFFSET_OFS, 10);
    meas(5000, 15, "offset");
    wr(posval_pkg::CTRL_OFS, 6);
    meas(20000, -10, "negative");
    wr(posval_pkg::OFFSET_OFS, 0);
    wr(posval_pkg::CTRL_OFS, 5);
    meas(25400, 100, "inch");
    wr(posval_pkg::CTRL_OFS, 4);
    wr(posval_pkg::RES_OFS, 500);
    meas(5000, 10, "res");
    wr(posval_pkg::RES_OFS, 4);
    wr(posval_pkg::RES_OFS, 50001);
    rdc(posval_pkg::RES_OFS, 500, "res kept");
    wr(posval_pkg::IRQ_MASK_OFS, 8);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, irq);
    wr(posval_pkg::IRQ_STAT_OFS, 8);
    repeat (2) @(posedge clk);
    chk("irq clr", 32'h0, irq);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, e);
    $display("test position done");
    wr(posval_pkg::RES_OFS, 1000);
    wr(posval_pkg::CTRL_OFS, 0);
    meas(5000, 5, "pre err");
    me <= 1'b1;
    wait_pos();
    chk("subst now", 32'h0, pos);
    chk("pos err", 32'h1, pos_err);
    me <= 1'b0;
    wr(posval_pkg::CTRL_OFS, 32'hC);
    wr(posval_pkg::DELAY_OFS, 3);
    meas(5000, 5, "pre hold");
    me <= 1'b1;
    @(posedge clk);
    wait_pos();
    // a short hold means the delay count is off
    chk("hold", 32'h1, 32'(n >= 11));
    chk("subst last", 32'h5, pos);
    me <= 1'b0;
    $display("test error done");
    wr(posval_pkg::CTRL_OFS, 32'h1C);
    wr(posval_pkg::OFFSET_OFS, 30);
    wr(posval_pkg::RES_OFS, 500);
    meas(5000, 70, "local");
    wr(posval_pkg::CTRL_OFS, 32'hC);
    meas(5000, 5, "host back");
    $display("test local done");
    wr(posval_pkg::OFFSET_OFS, 10);
    wr(posval_pkg::PRESET_OFS, 20);
    wr(posval_pkg::IO1_OFS, 3);
    ext1 <= 1'b0;
    repeat (4) @(posedge clk);
    chk("io1 oe", 32'h0, io1_oe);
    ext1 <= 1'b1;
    apb(1'b0, posval_pkg::STATUS_OFS, 32'h0);
    chk("preset on", 32'h1, {31'h0, r[0]});
    meas(5000, 25, "preset");
    wr(posval_pkg::IO2_OFS, 5);
    ext2 <= 1'b0;
    repeat (4) @(posedge clk);
    chk("laser off", 32'h0, laser_on);
    chk("io2 oe", 32'h0, io2_oe);
    ext2 <= 1'b1;
    repeat (4) @(posedge clk);
    chk("laser back", 32'h1, laser_on);
    $display("test ports done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- verif/sw_line_model.sv ----
// far-side switching line: the field device drives the pin while the port listens
`timescale 1ns/1ns
`default_nettype none
module sw_line_model (
  // port side
  input wire logic i_oe,
  input wire logic i_out,
  // field side
  input wire logic i_ext,
  output logic o_level
);
  // an output port owns the wire, otherwise the field contact sets it
  assign o_level = i_oe ? i_out : i_ext;
endmodule
`default_nettype wire

// ---- verilog/position_value_io.sv ----
// position post-processing, error substitution, switching ports and apb registers
`timescale 1ns/1ns
`default_nettype none
// How it works
// - distances come out in metric or inch; metric after reset
// - positive direction grows with distance, negative falls; positive default
// - output is measurement plus offset; new offset used from the next measurement loaded into the divider
// - offset kept in mm or inch/100, divided by the resolution factor together with the distance
// - an active preset replaces the offset, never added to it
// - teach pulse on a teach-configured input activates the preset register value; default 0 mm
// - resolution factor in thousandths, only 5..50000 accepted, default 1000
// - on error with delay on, hold last valid for delay; else substitute now
// - after the delay output last valid or zero; zero by default
// - switching port 1 is input or output, output by default
// - switching port 2 is input or output, output by default
// - an input port does none, preset teach or laser on/off; none default
// - an output port drives OR of its enabled conditions, inverted unless out_pol is set (inverted by default)
// - local test settings give way to host settings when local enable drops
module position_value_io #(
  parameter int unsigned TICK_CYCLES = posval_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // measurement core
  input wire logic i_meas_valid,
  input wire logic signed [31:0] i_meas_dist,
  input wire logic i_meas_error,
  input wire logic [posval_pkg::COND_W-1:0] i_cond,
  // position out
  output logic signed [31:0] o_pos,
  output logic o_pos_valid,
  output logic o_pos_error,
  output logic o_laser_on,
  // switching pins
  input wire logic i_io1,
  output logic o_io1,
  output logic o_io1_oe,
  input wire logic i_io2,
  output logic o_io2,
  output logic o_io2_oe,
  // interrupt
  output logic o_irq
);
  // tick counter is 24 bits and needs two states at least
  if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00FF_FFFF) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  posval_pkg::cfg_t host_cfg_r, host_cfg_nxt, local_cfg_r, local_cfg_nxt, act_cfg;
  logic local_en_r;
  logic preset_act_r;
  logic [31:0] prdata_r;
  logic [posval_pkg::EV_W-1:0] irq_stat_r, irq_mask_r, ev;
  logic err_d_r, hold_r, subst_r;
  logic [23:0] tick_r;
  logic [15:0] ms_r;
  logic signed [31:0] out_r, last_r;
  logic valid_r;
  posval_pkg::div_state_t div_st_r;
  logic [63:0] num_r;
  logic [32:0] rem_r;
  logic [31:0] den_r;
  logic [5:0] cnt_r;
  logic neg_r;

  // register-side decode
  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_setup = i_psel & ~i_penable & ~i_pwrite;
  wire a_ctrl = i_paddr == posval_pkg::CTRL_OFS;
  wire a_irq_stat = i_paddr == posval_pkg::IRQ_STAT_OFS;
  wire a_irq_mask = i_paddr == posval_pkg::IRQ_MASK_OFS;
  wire a_res = i_paddr == posval_pkg::RES_OFS;
  wire a_cfg = a_ctrl | a_res | (i_paddr == posval_pkg::OFFSET_OFS) |
               (i_paddr == posval_pkg::PRESET_OFS) | (i_paddr == posval_pkg::DELAY_OFS) |
               (i_paddr == posval_pkg::IO1_OFS) | (i_paddr == posval_pkg::IO2_OFS);
  wire hit = a_cfg | a_irq_stat | a_irq_mask | (i_paddr == posval_pkg::STATUS_OFS) |
             (i_paddr == posval_pkg::POS_OFS);
  wire wr_cfg = wr_en & a_cfg;
  wire res_ok = (i_pwdata[15:0] >= posval_pkg::RES_MIN) &&
                (i_pwdata[15:0] <= posval_pkg::RES_MAX) && (i_pwdata[31:16] == 16'h0000);
  wire local_rise = wr_en & a_ctrl & i_pwdata[posval_pkg::CTRL_LOCAL_EN] & ~local_en_r;

  function automatic posval_pkg::cfg_t cfg_write(input posval_pkg::cfg_t c,
                                                 input logic [7:0] a,
                                                 input logic [31:0] d,
                                                 input logic rok);
    cfg_write = c;
    if (a == posval_pkg::CTRL_OFS) begin
      cfg_write.unit_inch = d[posval_pkg::CTRL_INCH];
      cfg_write.dir_neg = d[posval_pkg::CTRL_NEG];
      cfg_write.dly_en = d[posval_pkg::CTRL_DLY_EN];
      cfg_write.subst_last = d[posval_pkg::CTRL_SUBST_LAST];
    end
    if (a == posval_pkg::OFFSET_OFS) begin
      cfg_write.offset = d;
    end
    if (a == posval_pkg::PRESET_OFS) begin
      cfg_write.preset = d;
    end
    if (a == posval_pkg::RES_OFS && rok) begin
      cfg_write.res = d[15:0];
    end
    if (a == posval_pkg::DELAY_OFS) begin
      cfg_write.dly_ms = d[15:0];
    end
    if (a == posval_pkg::IO1_OFS) begin
      cfg_write.io1 = posval_pkg::io_cfg_t'(d[12:0]);
    end
    if (a == posval_pkg::IO2_OFS) begin
      cfg_write.io2 = posval_pkg::io_cfg_t'(d[12:0]);
    end
  endfunction

  // local copy only while local enable is set
  assign host_cfg_nxt = (wr_cfg & ~local_en_r) ?
                        cfg_write(host_cfg_r, i_paddr, i_pwdata, res_ok) : host_cfg_r;
  assign local_cfg_nxt = (wr_cfg & local_en_r) ?
                         cfg_write(local_cfg_r, i_paddr, i_pwdata, res_ok) :
                         (local_rise ? host_cfg_r : local_cfg_r);
  assign act_cfg = local_en_r ? local_cfg_r : host_cfg_r;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      host_cfg_r <= posval_pkg::CFG_RST;
      local_cfg_r <= posval_pkg::CFG_RST;
      local_en_r <= 1'b0;
    end else begin
      host_cfg_r <= host_cfg_nxt;
      local_cfg_r <= local_cfg_nxt;
      if (wr_en & a_ctrl) begin
        local_en_r <= i_pwdata[posval_pkg::CTRL_LOCAL_EN];
      end
    end
  end

  // switching ports
  logic teach1, teach2, laser_off1, laser_off2, lvl1, lvl2;

  switch_port u_port1 (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_cfg(act_cfg.io1),
    .i_cond(i_cond),
    .i_pin(i_io1),
    .o_pin(o_io1),
    .o_pin_oe(o_io1_oe),
    .o_teach(teach1),
    .o_laser_off(laser_off1),
    .o_level(lvl1)
  );

  switch_port u_port2 (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_cfg(act_cfg.io2),
    .i_cond(i_cond),
    .i_pin(i_io2),
    .o_pin(o_io2),
    .o_pin_oe(o_io2_oe),
    .o_teach(teach2),
    .o_laser_off(laser_off2),
    .o_level(lvl2)
  );

  wire teach = teach1 | teach2;
  assign o_laser_on = ~(laser_off1 | laser_off2);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      preset_act_r <= 1'b0;
    end else if (teach) begin
      preset_act_r <= 1'b1;
    end
  end

  // numerator in micrometres times 1000, denominator digit size likewise
  wire signed [63:0] dist_x = {{32{i_meas_dist[31]}}, i_meas_dist};
  wire signed [63:0] dist_dir = act_cfg.dir_neg ? -(dist_x * posval_pkg::DIST_SCALE) :
                                                   dist_x * posval_pkg::DIST_SCALE;
  wire signed [31:0] ofs_sel = preset_act_r ? act_cfg.preset : act_cfg.offset;
  wire signed [63:0] ofs_x = {{32{ofs_sel[31]}}, ofs_sel};
  // offset unit follows the inch setting and is divided by resolution like the distance
  wire signed [63:0] ofs_num = ofs_x * (act_cfg.unit_inch ? posval_pkg::OFS_SCALE_IN :
                                                            posval_pkg::OFS_SCALE_MM);
  wire signed [63:0] num = dist_dir + ofs_num;
  wire [63:0] num_mag = num[63] ? 64'(-num) : 64'(num);
  wire [31:0] den = {16'h0000, act_cfg.res} *
                    (act_cfg.unit_inch ? posval_pkg::DEN_SCALE_IN : posval_pkg::DEN_SCALE_MM);
  wire [32:0] rem_sh = {rem_r[31:0], num_r[63]};
  wire rem_ge = rem_sh >= {1'b0, den_r};
  wire div_done = (div_st_r == posval_pkg::DIV_RUN) && (cnt_r == posval_pkg::DIV_LAST);
  wire [63:0] quot = {num_r[62:0], rem_ge};
  wire signed [31:0] q_sat = (|quot[63:31]) ? 32'sh7FFF_FFFF : signed'(quot[31:0]);
  wire signed [31:0] q_res = neg_r ? -q_sat : q_sat;
  wire load = i_meas_valid & ~i_meas_error & (div_st_r == posval_pkg::DIV_IDLE);

  // sequential divider: one sample in flight, later samples are dropped while busy
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_st_r <= posval_pkg::DIV_IDLE;
      num_r <= 64'h0;
      rem_r <= 33'h0;
      den_r <= 32'h0;
      cnt_r <= 6'h00;
      neg_r <= 1'b0;
    end else begin
      unique case (div_st_r)
        posval_pkg::DIV_IDLE: begin
          if (load) begin
            num_r <= num_mag;
            den_r <= den;
            rem_r <= 33'h0;
            cnt_r <= 6'h00;
            neg_r <= num[63];
            div_st_r <= posval_pkg::DIV_RUN;
          end
        end
        posval_pkg::DIV_RUN: begin
          num_r <= quot;
          rem_r <= rem_ge ? rem_sh - {1'b0, den_r} : rem_sh;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == posval_pkg::DIV_LAST) begin
            div_st_r <= posval_pkg::DIV_IDLE;
          end
        end
      endcase
    end
  end

  // error delay timing in whole milliseconds
  wire err_rise = i_meas_error & ~err_d_r;
  wire tick = tick_r == 24'(TICK_CYCLES - 1);
  wire delay_over = hold_r && (ms_r >= act_cfg.dly_ms);
  wire subst_go = (err_rise & ~act_cfg.dly_en) | delay_over;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_d_r <= 1'b0;
      hold_r <= 1'b0;
      subst_r <= 1'b0;
      tick_r <= 24'h0;
      ms_r <= 16'h0000;
    end else begin
      err_d_r <= i_meas_error;
      if (!i_meas_error) begin
        hold_r <= 1'b0;
        subst_r <= 1'b0;
      end else if (err_rise) begin
        hold_r <= act_cfg.dly_en;
        subst_r <= ~act_cfg.dly_en;
        tick_r <= 24'h0;
        ms_r <= 16'h0000;
      end else if (delay_over) begin
        hold_r <= 1'b0;
        subst_r <= 1'b1;
      end else if (hold_r) begin
        tick_r <= tick ? 24'h0 : tick_r + 24'h1;
        if (tick) begin
          ms_r <= ms_r + 16'h0001;
        end
      end
    end
  end

  wire signed [31:0] subst_val = act_cfg.subst_last ? last_r : 32'sh0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_r <= 32'sh0;
      last_r <= 32'sh0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (subst_go) begin
        out_r <= subst_val;
        valid_r <= 1'b1;
      end else if (div_done && !i_meas_error) begin
        out_r <= q_res;
        last_r <= q_res;
        valid_r <= 1'b1;
      end
    end
  end

  assign o_pos = out_r;
  assign o_pos_valid = valid_r;
  assign o_pos_error = i_meas_error;

  // interrupts: set wins over a same-cycle clear
  assign ev[posval_pkg::EV_TEACH] = teach;
  assign ev[posval_pkg::EV_ERROR] = err_rise;
  assign ev[posval_pkg::EV_SUBST] = subst_go;
  assign ev[posval_pkg::EV_RES_REJ] = wr_en & a_res & ~res_ok;
  wire [posval_pkg::EV_W-1:0] w1c = (wr_en & a_irq_stat) ? i_pwdata[posval_pkg::EV_W-1:0] :
                                                          {posval_pkg::EV_W{1'b0}};

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_r <= {posval_pkg::EV_W{1'b0}};
      irq_mask_r <= {posval_pkg::EV_W{1'b0}};
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      if (wr_en & a_irq_mask) begin
        irq_mask_r <= i_pwdata[posval_pkg::EV_W-1:0];
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // read data captured in the setup cycle, answered in the first access cycle
  wire [31:0] ctrl_rd = {27'h0, local_en_r, act_cfg.subst_last, act_cfg.dly_en,
                         act_cfg.dir_neg, act_cfg.unit_inch};
  wire [31:0] status_rd = {26'h0, lvl2, lvl1, o_laser_on, subst_r, hold_r, preset_act_r};
  wire [31:0] rd_mux =
    a_ctrl ? ctrl_rd :
    (i_paddr == posval_pkg::OFFSET_OFS) ? act_cfg.offset :
    (i_paddr == posval_pkg::PRESET_OFS) ? act_cfg.preset :
    a_res ? {16'h0000, act_cfg.res} :
    (i_paddr == posval_pkg::DELAY_OFS) ? {16'h0000, act_cfg.dly_ms} :
    (i_paddr == posval_pkg::IO1_OFS) ? {19'h0, act_cfg.io1} :
    (i_paddr == posval_pkg::IO2_OFS) ? {19'h0, act_cfg.io2} :
    (i_paddr == posval_pkg::STATUS_OFS) ? status_rd :
    (i_paddr == posval_pkg::POS_OFS) ? out_r :
    a_irq_stat ? {28'h0, irq_stat_r} :
    a_irq_mask ? {28'h0, irq_mask_r} : 32'h0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata_r <= 32'h0;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_err_start_delayed;
    $rose(i_meas_error) ##0 act_cfg.dly_en ##0 (act_cfg.dly_ms != 16'h0000);
  endsequence

  a_res_in_range: assert property (
    act_cfg.res >= posval_pkg::RES_MIN && act_cfg.res <= posval_pkg::RES_MAX)
    else $error("resolution factor outside accepted range");
  a_no_delay_subst: assert property (
    ($rose(i_meas_error) && !act_cfg.dly_en) |=> subst_r ##0 o_pos_valid)
    else $error("substitute not applied at once with delay off");
  a_delay_holds: assert property (
    s_err_start_delayed |=> (!subst_r && $stable(o_pos)) [*2])
    else $error("last valid position not held during error delay");
  a_zero_subst: assert property (
    (subst_r && !act_cfg.subst_last && $rose(subst_r)) |-> o_pos == 32'sh0)
    else $error("zero substitute not output");
  a_teach_preset: assert property (
    teach |=> preset_act_r)
    else $error("teach did not arm preset");
  a_local_revert: assert property (
    local_en_r |=> $stable(host_cfg_r))
    else $error("host settings changed while local enable set");
  a_pos_update: assert property (
    (div_done && !i_meas_error && !subst_go) |=> o_pos == $past(q_res) && o_pos_valid)
    else $error("position not updated from computed value");
  a_irq_sticky: assert property (
    (|ev) |=> ((irq_stat_r & $past(ev)) == $past(ev)))
    else $error("event did not set its status bit");
  a_div_length: assert property (
    load |=> (div_st_r == posval_pkg::DIV_RUN) [*8])
    else $error("divider finished early");
endmodule
`default_nettype wire

// ---- verilog/posval_pkg.sv ----
// shared constants and types for the position value and switching port block
`default_nettype none
package posval_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] ERR_DELAY_MS_RST = 16'h0064;
  // resolution limits, thousandths
  localparam logic [15:0] RES_MIN = 16'h0005;
  localparam logic [15:0] RES_MAX = 16'hC350;
  localparam logic [15:0] RES_RST = 16'h03E8;
  // numerator scale: raw distance is in micrometres
  localparam logic signed [63:0] DIST_SCALE = 64'sh0000_0000_0000_03E8;
  localparam logic signed [63:0] OFS_SCALE_MM = 64'sh0000_0000_000F_4240;
  localparam logic signed [63:0] OFS_SCALE_IN = 64'sh0000_0000_0003_E030;
  localparam logic [31:0] DEN_SCALE_MM = 32'h0000_03E8;
  localparam logic [31:0] DEN_SCALE_IN = 32'h0000_00FE;
  localparam logic [5:0] DIV_LAST = 6'h3F;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OFFSET_OFS = 8'h04;
  localparam logic [7:0] PRESET_OFS = 8'h08;
  localparam logic [7:0] RES_OFS = 8'h0C;
  localparam logic [7:0] DELAY_OFS = 8'h10;
  localparam logic [7:0] IO1_OFS = 8'h14;
  localparam logic [7:0] IO2_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] POS_OFS = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;
  // ctrl bit positions
  localparam int unsigned CTRL_INCH = 0;
  localparam int unsigned CTRL_NEG = 1;
  localparam int unsigned CTRL_DLY_EN = 2;
  localparam int unsigned CTRL_SUBST_LAST = 3;
  localparam int unsigned CTRL_LOCAL_EN = 4;
  // interrupt event bits
  localparam int unsigned EV_TEACH = 0;
  localparam int unsigned EV_ERROR = 1;
  localparam int unsigned EV_SUBST = 2;
  localparam int unsigned EV_RES_REJ = 3;
  localparam int unsigned EV_W = 4;
  // switching input functions
  typedef enum logic [1:0] {
    IN_NONE = 2'b00,
    IN_TEACH = 2'b01,
    IN_LASER = 2'b10
  } in_func_t;
  // output condition bits
  localparam int unsigned COND_W = 8;
  // port config, low bits match the register layout
  typedef struct packed {
    logic out_pol;
    logic [7:0] out_mask;
    logic in_pol;
    logic [1:0] in_func;
    logic is_input;
  } io_cfg_t;
  typedef struct packed {
    logic unit_inch;
    logic dir_neg;
    logic dly_en;
    logic subst_last;
    logic signed [31:0] offset;
    logic signed [31:0] preset;
    logic [15:0] res;
    logic [15:0] dly_ms;
    io_cfg_t io1;
    io_cfg_t io2;
  } cfg_t;
  localparam io_cfg_t IO1_RST = '{out_pol: 1'b0, out_mask: 8'hC0, in_pol: 1'b0,
                                  in_func: IN_NONE, is_input: 1'b0};
  localparam io_cfg_t IO2_RST = '{out_pol: 1'b0, out_mask: 8'h38, in_pol: 1'b0,
                                  in_func: IN_NONE, is_input: 1'b0};
  localparam cfg_t CFG_RST = '{unit_inch: 1'b0, dir_neg: 1'b0, dly_en: 1'b1,
                               subst_last: 1'b0, offset: 32'sh0, preset: 32'sh0,
                               res: RES_RST, dly_ms: ERR_DELAY_MS_RST,
                               io1: IO1_RST, io2: IO2_RST};
  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } div_state_t;
endpackage
`default_nettype wire

// ---- verilog/switch_port.sv ----
// one bidirectional switching port: input sense or OR-ed output drive
`timescale 1ns/1ns
`default_nettype none
module switch_port (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // configuration and conditions
  input wire posval_pkg::io_cfg_t i_cfg,
  input wire logic [posval_pkg::COND_W-1:0] i_cond,
  // pin
  input wire logic i_pin,
  output logic o_pin,
  output logic o_pin_oe,
  // decoded functions
  output logic o_teach,
  output logic o_laser_off,
  output logic o_level
);
  logic sync1_r;
  logic sync2_r;
  logic act_d_r;
  logic pin_r;
  wire in_act;
  wire out_any;
  wire func_teach;
  wire func_laser;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      act_d_r <= 1'b0;
      pin_r <= 1'b1;
    end else begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
      act_d_r <= in_act;
      pin_r <= i_cfg.out_pol ? out_any : ~out_any;
    end
  end

  assign in_act = i_cfg.in_pol ? sync2_r : ~sync2_r;
  assign func_teach = i_cfg.is_input && (i_cfg.in_func == posval_pkg::IN_TEACH);
  assign func_laser = i_cfg.is_input && (i_cfg.in_func == posval_pkg::IN_LASER);
  assign o_teach = func_teach & in_act & ~act_d_r;
  assign o_laser_off = func_laser & in_act;
  assign out_any = |(i_cond & i_cfg.out_mask);
  assign o_pin = pin_r;
  assign o_pin_oe = ~i_cfg.is_input;
  assign o_level = i_cfg.is_input ? in_act : out_any;

  a_teach_single: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_teach |=> !o_teach)
    else $error("teach pulse longer than one cycle");
  a_out_drive: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_cfg.is_input |=> o_pin == ($past(|(i_cond & i_cfg.out_mask)) ^ !$past(i_cfg.out_pol)))
    else $error("output pin does not follow masked conditions");
  a_sense_pol: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_laser_off |-> ($past(i_pin, 2) == i_cfg.in_pol))
    else $error("laser input ignores polarity");
endmodule
`default_nettype wire
